// [src/iowfd_core.sv]
// Fault checking, message decode and function decode, AHB-Lite slave.
// Assumes a single-master AHB-Lite bus, word accesses only.
`timescale 1ns/1ns
module iowfd_core
    import iowfd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic psResetPulse,
    output logic physMode,
    output logic dispatching,
    output logic faultPulse,
    output logic [4:0] faultOpId
);
    logic [31:0] rdData_ff;
    logic wrPend_ff;
    logic [7:0] wrAddr_ff;
    logic [5:0] entry_ff [NUM_ENTRIES];
    logic [9:0] fcode_ff [NUM_ENTRIES];
    logic [15:0] fdisp_ff [NUM_ENTRIES];
    logic [15:0] carrier_ff [16];
    logic [15:0] blkCount_ff;
    logic [23:0] segBase_ff;
    logic [15:0] selIndex_ff, selState_ff, curIndex_ff;
    logic procRecv_ff, bcastMode_ff, running_ff, flushPulse_ff;
    logic [2:0] suspend_ff;
    logic msgUnused_ff, fnBad_ff;
    logic [7:0] fnCode_ff;
    logic [4:0] fnOpId_ff;
    logic psRst_ff, phys_ff, disp_ff, fault_ff;
    logic [4:0] faultOp_ff;

    function automatic logic fnLegal(input logic [7:0] code,
                                     input logic inPhys);
        fnLegal = inPhys ? (code <= FN_PHY_MAX) : (code <= FN_LOG_MAX);
    endfunction

    logic addrPhase, rdAddr;
    assign addrPhase = hsel && hready && htrans[1];
    assign rdAddr = addrPhase && !hwrite;

    // Write data arrives one cycle after its address phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPend_ff <= 1'b0;
            wrAddr_ff <= 8'h00;
        end else begin
            wrPend_ff <= addrPhase && hwrite;
            wrAddr_ff <= haddr[7:0];
        end
    end

    logic wrEn;
    logic [7:0] wa;
    logic [2:0] waEnt;
    assign wrEn = wrPend_ff;
    assign wa = wrAddr_ff;
    assign waEnt = wa[4:2];

    // Access attempt: word at A_ACCESS
    // [2:0] entry, [3] write, [4] double byte, [20:5] displacement
    logic accEn, accWr, accDbl;
    logic [2:0] accEnt;
    logic [15:0] accDisp;
    logic [5:0] es;
    logic [24:0] sum;
    logic [9:0] nxt_fcode;
    assign accEn = wrEn && (wa == A_ACCESS) &&
                   (hwdata[2:0] < 3'(NUM_ENTRIES));
    assign accEnt = hwdata[2:0];
    assign accWr = hwdata[3];
    assign accDbl = hwdata[4];
    assign accDisp = hwdata[20:5];
    assign es = entry_ff[accEnt];
    assign sum = {1'b0, segBase_ff} + {9'h000, accDisp};

    always_comb begin
        nxt_fcode = 10'h000;
        nxt_fcode[FC_RW] = accWr;
        nxt_fcode[FC_MEMOVF] = sum > MEM_LIMIT;
        nxt_fcode[FC_DIR] = accWr ? !es[ES_DIR_HI] : !es[ES_DIR_LO];
        nxt_fcode[FC_POST] = es[ES_TS_HI:ES_TS_LO] != TS_RUN;
        nxt_fcode[FC_PBLK] = es[ES_MODE] && accDbl &&
                             (blkCount_ff == 16'h0001);
        nxt_fcode[FC_BLK] = es[ES_MODE] && (blkCount_ff == 16'h0000) &&
                            (es[ES_TS_HI:ES_TS_LO] == TS_RUN);
    end

    logic accFault;
    assign accFault = accEn && es[ES_VALID] &&
                      (|nxt_fcode[FC_BLK:FC_MEMOVF]);

    logic [4:0] msgCode;
    logic msgEn, closeWin;
    assign msgEn = wrEn && (wa == A_MSG);
    assign msgCode = hwdata[4:0];
    assign closeWin = msgEn &&
                      (msgCode == MSG_CLOSE || msgCode == MSG_PHYS);

    // Map entries, fault codes and displacements
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_ENTRIES; i++) begin
                entry_ff[i] <= 6'h00;
                fcode_ff[i] <= 10'h000;
                fdisp_ff[i] <= 16'h0000;
            end
        end else begin
            if (wrEn && wa[7:5] == A_ENTRY0[7:5] &&
                waEnt < 3'(NUM_ENTRIES)) begin
                entry_ff[waEnt] <= hwdata[5:0];
            end
            if (accFault) begin
                fcode_ff[accEnt] <= nxt_fcode;
                fdisp_ff[accEnt] <= accDisp;
                entry_ff[accEnt][ES_TS_HI:ES_TS_LO] <= TS_FAULT;
            end
            if (closeWin) begin
                for (int i = 0; i < NUM_WINDOWS_CLOSE; i++) begin
                    entry_ff[i][ES_VALID] <= 1'b0;
                end
            end
        end
    end

    // Block count and segment base
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            blkCount_ff <= 16'h0000;
            segBase_ff <= 24'h000000;
        end else if (wrEn && wa == A_BASE) begin
            segBase_ff <= hwdata[23:0];
        end else if (wrEn && wa == A_STATUS) begin
            blkCount_ff <= hwdata[15:0];
        end else if (accEn && !accFault && es[ES_MODE] &&
                     es[ES_VALID]) begin
            blkCount_ff <= blkCount_ff - (accDbl ? 16'h0002 : 16'h0001);
        end
    end

    // Carrier segment: double bytes written by index
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) begin
                carrier_ff[i] <= 16'h0000;
            end
            procRecv_ff <= 1'b0;
        end else if (wrEn && wa == A_CARRIER) begin
            carrier_ff[hwdata[19:16]] <= hwdata[15:0];
            procRecv_ff <= hwdata[31];
        end
    end

    // Message decode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            selIndex_ff <= 16'h0000;
            selState_ff <= 16'h0000;
            curIndex_ff <= IDX_INVALID;
            disp_ff <= 1'b0;
            running_ff <= 1'b0;
            bcastMode_ff <= 1'b0;
            flushPulse_ff <= 1'b0;
            suspend_ff <= 3'h0;
            psRst_ff <= 1'b0;
            phys_ff <= 1'b0;
            msgUnused_ff <= 1'b0;
        end else begin
            psRst_ff <= 1'b0;
            flushPulse_ff <= 1'b0;
            if (msgEn) begin
                msgUnused_ff <= 1'b0;
                unique case (msgCode)
                    MSG_SELECT: begin
                        curIndex_ff <= IDX_INVALID;
                        if (procRecv_ff) begin
                            selIndex_ff <= carrier_ff[CARRIER_IDX_OFF];
                            selState_ff <= carrier_ff[CARRIER_STATE_OFF];
                            disp_ff <= 1'b1;
                        end
                    end
                    MSG_START: running_ff <= 1'b1;
                    MSG_STOP: running_ff <= 1'b0;
                    MSG_BCSET: bcastMode_ff <= 1'b1;
                    MSG_BCCLR: bcastMode_ff <= 1'b0;
                    MSG_FLUSH: flushPulse_ff <= 1'b1;
                    MSG_SUSPF: suspend_ff <= 3'h6;
                    MSG_SUSP: suspend_ff <= 3'h7;
                    MSG_CLOSE: ; // Handled with the map entries
                    MSG_PSRST: psRst_ff <= 1'b1;
                    MSG_PHYS: phys_ff <= 1'b1;
                    default: msgUnused_ff <= 1'b1;
                endcase
            end
            // Physical mode left only by reset
        end
    end

    // Function decode; operator id is code plus three
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fnCode_ff <= 8'h00;
            fnOpId_ff <= 5'h00;
            fnBad_ff <= 1'b0;
            fault_ff <= 1'b0;
            faultOp_ff <= 5'h00;
        end else begin
            fault_ff <= 1'b0;
            if (wrEn && wa == A_FUNC) begin
                fnCode_ff <= hwdata[7:0];
                fnBad_ff <= !fnLegal(hwdata[7:0], phys_ff);
                fnOpId_ff <= hwdata[4:0] + OPID_BASE;
                if (!fnLegal(hwdata[7:0], phys_ff)) begin
                    fault_ff <= 1'b1;
                    faultOp_ff <= hwdata[4:0] + OPID_BASE;
                end
            end else if (accFault) begin
                fault_ff <= 1'b1;
                faultOp_ff <= fnOpId_ff;
            end
        end
    end

    // Read mux; registered for one wait-free data phase
    logic [7:0] ra;
    logic [31:0] nxt_rdData;
    assign ra = haddr[7:0];
    always_comb begin
        nxt_rdData = 32'h00000000;
        if (ra[7:5] == A_ENTRY0[7:5] && ra[4:2] < 3'(NUM_ENTRIES)) begin
            nxt_rdData = {26'h0, entry_ff[ra[4:2]]};
        end else if (ra[7:5] == A_FAULT0[7:5] &&
                     ra[4:2] < 3'(NUM_ENTRIES)) begin
            nxt_rdData = {22'h0, fcode_ff[ra[4:2]]};
        end else if (ra[7:5] == A_FDISP0[7:5] &&
                     ra[4:2] < 3'(NUM_ENTRIES)) begin
            nxt_rdData = {16'h0, fdisp_ff[ra[4:2]]};
        end else begin
            unique case (ra)
                A_CTRL: nxt_rdData = {22'h0, msgUnused_ff, suspend_ff,
                                      flushPulse_ff, bcastMode_ff,
                                      running_ff, disp_ff, phys_ff,
                                      procRecv_ff};
                A_STATUS: nxt_rdData = {16'h0, blkCount_ff};
                A_BASE: nxt_rdData = {8'h0, segBase_ff};
                A_FUNC: nxt_rdData = {18'h0, fnBad_ff, fnOpId_ff,
                                      fnCode_ff};
                A_SEL: nxt_rdData = {selState_ff, selIndex_ff};
                A_MSG: nxt_rdData = {16'h0, curIndex_ff};
                default: nxt_rdData = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_ff <= 32'h00000000;
        end else if (rdAddr) begin
            rdData_ff <= nxt_rdData;
        end
    end

    assign hrdata = rdData_ff;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign psResetPulse = psRst_ff;
    assign physMode = phys_ff;
    assign dispatching = disp_ff;
    assign faultPulse = fault_ff;
    assign faultOpId = faultOp_ff;
endmodule // iowfd_core

// [pkg/iowfd_pkg.sv]
// Constants for the I/O window fault and message decode block.
// Assumes one 100 MHz clock and an AHB-Lite register slave.
package iowfd_pkg;
    localparam int ADDR_W = 8;
    localparam logic [24:0] MEM_LIMIT = 25'h0FFFFFF;
    localparam int NUM_ENTRIES = 5;
    localparam int NUM_WINDOWS_CLOSE = 4;
    // Fault code bit positions
    localparam int FC_RW = 0;
    localparam int FC_BUSERR = 1;
    localparam int FC_RIGHTS = 2;
    localparam int FC_BOUND = 3;
    localparam int FC_MEMOVF = 4;
    localparam int FC_DIR = 5;
    localparam int FC_POST = 6;
    localparam int FC_PBLK = 7;
    localparam int FC_BLK = 8;
    // Entry state field positions
    localparam int ES_VALID = 0;
    localparam int ES_MODE = 1;
    localparam int ES_DIR_LO = 2;
    localparam int ES_DIR_HI = 3;
    localparam int ES_TS_LO = 4;
    localparam int ES_TS_HI = 5;
    localparam logic [1:0] TS_RUN = 2'h0;
    localparam logic [1:0] TS_FAULT = 2'h3;
    // Message codes
    localparam logic [4:0] MSG_SELECT = 5'h00;
    localparam logic [4:0] MSG_START = 5'h01;
    localparam logic [4:0] MSG_STOP = 5'h02;
    localparam logic [4:0] MSG_BCSET = 5'h03;
    localparam logic [4:0] MSG_BCCLR = 5'h04;
    localparam logic [4:0] MSG_FLUSH = 5'h05;
    localparam logic [4:0] MSG_SUSPF = 5'h06;
    localparam logic [4:0] MSG_SUSP = 5'h07;
    localparam logic [4:0] MSG_CLOSE = 5'h0F;
    localparam logic [4:0] MSG_PSRST = 5'h10;
    localparam logic [4:0] MSG_PHYS = 5'h11;
    localparam logic [4:0] MSG_MAX = 5'h11;
    localparam logic [3:0] CARRIER_IDX_OFF = 4'h8;
    localparam logic [3:0] CARRIER_STATE_OFF = 4'h9;
    localparam logic [7:0] FN_LOG_MAX = 8'h1A;
    localparam logic [7:0] FN_PHY_MAX = 8'h03;
    localparam logic [4:0] OPID_BASE = 5'h03;
    // Register byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_ACCESS = 8'h08;
    localparam logic [7:0] A_BASE = 8'h0C;
    localparam logic [7:0] A_MSG = 8'h10;
    localparam logic [7:0] A_CARRIER = 8'h14;
    localparam logic [7:0] A_FUNC = 8'h18;
    localparam logic [7:0] A_SEL = 8'h1C;
    localparam logic [7:0] A_ENTRY0 = 8'h20;
    localparam logic [7:0] A_FAULT0 = 8'h40;
    localparam logic [7:0] A_FDISP0 = 8'h60;
    localparam logic [15:0] IDX_INVALID = 16'hFFFF;
endpackage

// [dv/iowfd_ps_model.sv]
// Peripheral subsystem side: counts the resets it is handed.
// Assumes the reset request arrives as a one-cycle pulse on clk.
`timescale 1ns/1ns
module iowfd_ps_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psResetPulse,
    output int resetCount
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resetCount <= 0;
        end else if (psResetPulse) begin
            resetCount <= resetCount + 1;
        end
    end
endmodule // iowfd_ps_model

// [dv/iowfd_props.sv]
// Port checker for the decode block.
// Bound to iowfd_core; sees its ports only, one clock domain.
`timescale 1ns/1ns
module iowfd_props
    import iowfd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic psResetPulse,
    input wire logic physMode,
    input wire logic dispatching,
    input wire logic faultPulse,
    input wire logic [4:0] faultOpId
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Address phase then data phase; ends on the data edge
    sequence wrSeq(logic [7:0] a);
        hsel && hready && htrans[1] && hwrite && haddr[7:0] == a ##1 1'b1;
    endsequence
    sequence msgSeq(logic [4:0] c);
        wrSeq(A_MSG) ##0 hwdata[4:0] == c;
    endsequence
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not zero-wait OKAY");
    chk_psreset_cause: assert property (msgSeq(MSG_PSRST) |=> psResetPulse)
        else $error("no subsystem reset after code 16");
    chk_psreset_once: assert property (psResetPulse |=> !psResetPulse)
        else $error("subsystem reset longer than a cycle");
    chk_phys_enter: assert property (msgSeq(MSG_PHYS) |=> physMode)
        else $error("no physical mode after code 17");
    chk_phys_hold: assert property (physMode |=> physMode)
        else $error("physical mode left without reset");
    chk_log_bad: assert property (wrSeq(A_FUNC) ##0 !physMode
        && hwdata[7:0] > FN_LOG_MAX && hwdata[7:0] < 8'h1D |=> faultPulse
        && faultOpId == $past(hwdata[4:0]) + OPID_BASE)
        else $error("bad logical code not faulted");
    chk_log_good: assert property (wrSeq(A_FUNC) ##0 !physMode
        && hwdata[7:0] <= FN_LOG_MAX |=> !faultPulse)
        else $error("good logical code faulted");
    chk_phys_bad: assert property (wrSeq(A_FUNC) ##0 physMode
        && hwdata[7:0] > FN_PHY_MAX && hwdata[7:0] < 8'h1D |=> faultPulse)
        else $error("bad physical code not faulted");
    chk_phys_good: assert property (wrSeq(A_FUNC) ##0 physMode
        && hwdata[7:0] <= FN_PHY_MAX |=> !faultPulse)
        else $error("good physical code faulted");
endmodule // iowfd_props
bind iowfd_core iowfd_props u_props (.clk, .rst_n, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
    .hresp, .psResetPulse, .physMode, .dispatching, .faultPulse,
    .faultOpId);

// [dv/testbench.sv]
// Self-checking bench for the decode block over AHB-Lite.
// Assumes zero-wait slave; the subsystem model counts resets.
`timescale 1ns/1ns
module testbench;
    import iowfd_pkg::*;
    logic clk, rst_n, hwrite, hreadyout, hresp, psResetPulse;
    logic physMode, dispatching, faultPulse;
    logic [1:0] htrans;
    logic [4:0] faultOpId;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    int bad_count, tests_run, cyc, resetCount;
    iowfd_core DUT (.clk(clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .psResetPulse(psResetPulse), .physMode(physMode),
        .dispatching(dispatching), .faultPulse(faultPulse),
        .faultOpId(faultOpId));
    iowfd_ps_model ps (.clk(clk), .rst_n(rst_n),
        .psResetPulse(psResetPulse), .resetCount(resetCount));
    task automatic close_out();
        $display("tests %0d bad %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rc(string nm, logic [7:0] a, logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(nm, rdv, exp);
    endtask
    function automatic logic [31:0] acc(logic [2:0] e, logic w, logic d,
                                        logic [15:0] disp);
        return {11'h0, disp, d, w, e};
    endfunction
    task automatic t_reset();
        rc("ctrl", A_CTRL, 32'h0);
        rc("sel", A_SEL, 32'h0);
        rc("unmapped", 8'hFC, 32'h0);
        chk("phys", {31'h0, physMode}, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_fault();
        wr(A_BASE, 32'h00FFFFF0);
        // Entry 1 valid, reads only
        wr(A_ENTRY0 + 8'h04, 32'h05);
        wr(A_ACCESS, acc(3'h1, 1'b1, 1'b0, 16'h0020));
        @(posedge clk);
        chk("faultPulse", {31'h0, faultPulse}, 32'h1);
        rc("fault1", A_FAULT0 + 8'h04, 32'h31);
        rc("fdisp1", A_FDISP0 + 8'h04, 32'h20);
        rc("entry1", A_ENTRY0 + 8'h04, 32'h35);
        wr(A_ACCESS, acc(3'h1, 1'b0, 1'b0, 16'h0000));
        rc("post", A_FAULT0 + 8'h04, 32'h40);
        // Last byte of memory is still in range
        wr(A_ENTRY0 + 8'h08, 32'h0D);
        wr(A_ACCESS, acc(3'h2, 1'b0, 1'b0, 16'h000F));
        rc("edge", A_FAULT0 + 8'h08, 32'h0);
        // Entry 2 write-only: a read must fault on direction
        wr(A_ENTRY0 + 8'h08, 32'h09);
        wr(A_ACCESS, acc(3'h2, 1'b0, 1'b0, 16'h0001));
        rc("rdDir", A_FAULT0 + 8'h08, 32'h20);
        $display("test fault done");
    endtask
    task automatic t_block();
        wr(A_BASE, 32'h0);
        wr(A_ENTRY0, 32'h07);
        wr(A_STATUS, 32'h1);
        wr(A_ACCESS, acc(3'h0, 1'b0, 1'b1, 16'h0000));
        rc("pblk", A_FAULT0, 32'h80);
        wr(A_ENTRY0, 32'h07);
        wr(A_STATUS, 32'h0);
        wr(A_ACCESS, acc(3'h0, 1'b0, 1'b0, 16'h0000));
        rc("blk", A_FAULT0, 32'h100);
        $display("test block done");
    endtask
    task automatic t_func_log();
        for (int c = 0; c <= 27; c++) begin
            wr(A_FUNC, 32'(c));
            rc("func", A_FUNC, {18'h0, c > 26, 5'(c + 3), 8'(c)});
        end
        chk("opId", {27'h0, faultOpId}, 32'd30);
        // Access fault reports the id of the function in force
        wr(A_FUNC, 32'h08);
        wr(A_ACCESS, acc(3'h0, 1'b0, 1'b0, 16'h0000));
        @(posedge clk);
        chk("accFault", {31'h0, faultPulse}, 32'h1);
        chk("accOpId", {27'h0, faultOpId}, 32'd11);
        $display("test logical functions done");
    endtask
    task automatic t_close(logic [4:0] code);
        for (int n = 0; n < 5; n++) begin
            wr(A_ENTRY0 + 8'(4 * n), 32'h1);
        end
        wr(A_MSG, 32'(code));
        for (int n = 0; n < 5; n++) begin
            xfer(1'b0, A_ENTRY0 + 8'(4 * n), 32'h0);
            chk("valid", {31'h0, rdv[0]}, {31'h0, n == 4});
        end
    endtask
    task automatic t_msg();
        logic [4:0] codes [7] = '{1, 3, 4, 2, 5, 6, 7};
        logic [5:0] exp [7] = '{6'h01, 6'h03, 6'h01, 6'h00, 6'h00, 6'h30,
                                6'h38};
        wr(A_CARRIER, 32'h00075555);
        wr(A_CARRIER, 32'h00081234);
        // No process received yet: nothing selected
        wr(A_MSG, 32'(MSG_SELECT));
        rc("noSel", A_SEL, 32'h0);
        chk("noDisp", {31'h0, dispatching}, 32'h0);
        wr(A_CARRIER, 32'h8009ABCD);
        wr(A_MSG, 32'(MSG_SELECT));
        rc("sel", A_SEL, 32'hABCD1234);
        rc("curIdx", A_MSG, 32'h0000FFFF);
        rc("ctrl", A_CTRL, 32'h5);
        chk("dispatching", {31'h0, dispatching}, 32'h1);
        // Flush bit left unchecked: pulse or level is open
        for (int i = 0; i < 7; i++) begin
            wr(A_MSG, 32'(codes[i]));
            xfer(1'b0, A_CTRL, 32'h0);
            chk("ctrlBits", {26'h0, rdv[8:3] & 6'h3B}, {26'h0, exp[i]});
        end
        for (int c = 8; c <= 14; c++) begin
            wr(A_MSG, 32'(c));
            xfer(1'b0, A_CTRL, 32'h0);
            chk("unused", {31'h0, rdv[9]}, 32'h1);
        end
        chk("psIdle", resetCount, 32'h0);
        t_close(MSG_CLOSE);
        chk("physStay", {31'h0, physMode}, 32'h0);
        wr(A_MSG, 32'(MSG_PSRST));
        repeat (2) @(posedge clk);
        chk("psReset", resetCount, 32'h1);
        t_close(MSG_PHYS);
        chk("physOn", {31'h0, physMode}, 32'h1);
        $display("test messages done");
    endtask
    task automatic t_func_phys();
        for (int c = 0; c <= 4; c++) begin
            wr(A_FUNC, 32'(c));
            @(posedge clk);
            chk("physFault", {31'h0, faultPulse}, {31'h0, c == 4});
        end
        $display("test physical functions done");
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            close_out();
        end
    end
    initial begin
        rst_n = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_fault();
        t_block();
        t_func_log();
        t_msg();
        t_func_phys();
        close_out();
    end
endmodule // testbench
